/* File: inc/msl_pkg.sv */
// constants and types shared by the motion state linker
package msl_pkg;
  // detector operation select field
  localparam logic [1:0] MSL_MODE_DEFAULT = 2'h0;
  localparam logic [1:0] MSL_MODE_LINKED  = 2'h1;
  localparam logic [1:0] MSL_MODE_LOOP    = 2'h2;
  localparam logic [1:0] MSL_MODE_RST     = MSL_MODE_DEFAULT;
  // event channel positions
  localparam int unsigned MSL_CH_ACT   = 0;
  localparam int unsigned MSL_CH_INACT = 1;
  localparam int unsigned MSL_NUM_CH   = 2;
  // reset values
  localparam logic MSL_AWAKE_RST = 1'h1;
  localparam logic MSL_WAKE_RST  = 1'h0;
  // which detector the linked sequence is waiting on, one-hot
  typedef enum logic [1:0] {
    MSL_SEEK_ACT   = 2'h1,
    MSL_SEEK_INACT = 2'h2
  } msl_phase_t;
endpackage

/* File: inc/msl_evt_if.sv */
// event channel bundle between the linker and its pending-event holder
`timescale 1ns/1ps
`default_nettype none
interface msl_evt_if;
  logic [1:0] detect;
  logic [1:0] clear;
  logic [1:0] pend;
  logic [1:0] done;
  modport ctrl (output detect, output clear, input pend, input done);
  modport hold (input detect, input clear, output pend, output done);
endinterface
`default_nettype wire

/* File: core/msl_event_hold.sv */
// pending flags for the activity and inactivity events
`timescale 1ns/1ps
`default_nettype none
module msl_event_hold
  import msl_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // event channels
  msl_evt_if.hold   ev
);
  typedef struct packed {
    logic [1:0] pend;
  } msl_hold_t;

  msl_hold_t st;
  msl_hold_t next_st;

  // a clear only removes what was pending; a new detection wins
  always_comb begin
    next_st = st;
    next_st.pend = ev.detect | (st.pend & ~ev.clear);
  end

  // serviced pulse when a pending event is cleared
  assign ev.pend = st.pend;
  assign ev.done = st.pend & ev.clear;

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // event stays pending until its clear
  a_pend_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st.pend[0] && !ev.clear[0] |=> st.pend[0])
    else $error("pending event lost without clear");
endmodule
`default_nettype wire

/* File: core/msl_linker.sv */
// activity/inactivity linking, awake flag and autosleep control
`timescale 1ns/1ps
`default_nettype none
// How it works
// - detectors run only once the host has enabled each of them
// - default mode runs both; an event stays pending until host reads status
// - linked: one detector at a time; after activity only inactivity runs
// - linked: after inactivity the device is stationary and seeks activity
// - linked: activity first after reset; next detector waits for service
// - awake flag is one after reset
// - awake clears on serviced inactivity, sets on serviced activity
// - loop mode alternates like linked but clears events by itself
// - loop: awake set on entering measurement, held until act then inact
// - autosleep: wake-up mode on serviced inactivity, measure on activity
// - autosleep is ignored in default mode
// - autosleep is blocked while low noise operation is selected
// - awake level can be routed to either interrupt pin
// - sample buffer stops in wake-up mode and while autosleep is active
// - referenced linked: activity reference reloads when seeking activity
module msl_linker
  import msl_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // host configuration
  input  wire logic [1:0] mode_sel,
  input  wire logic       act_en,
  input  wire logic       inact_en,
  input  wire logic       act_ref,
  input  wire logic       inact_ref,
  input  wire logic       autosleep_en,
  input  wire logic       low_noise,
  input  wire logic       fifo_en,
  input  wire logic       irq1_awake,
  input  wire logic       irq2_awake,
  // host actions
  input  wire logic       status_read,
  input  wire logic       measure_start,
  // detector results
  input  wire logic       act_detect,
  input  wire logic       inact_detect,
  // detector control
  output logic            act_run,
  output logic            inact_run,
  output logic            act_ref_load,
  output logic            inact_ref_load,
  // status
  output logic            act_event,
  output logic            inact_event,
  output logic            awake,
  output logic            wake_mode,
  output logic            fifo_run,
  // interrupt pins
  output logic            first_irq_pin,
  output logic            second_irq_pin
);
  import msl_pkg::*;

  typedef struct packed {
    msl_phase_t phase;
    logic       awake;
    logic       wake_mode;
    logic       act_run;
    logic       inact_run;
    logic       fifo_run;
    logic       act_ref_load;
    logic       inact_ref_load;
    logic       irq1;
    logic       irq2;
  } msl_state_t;

  msl_state_t st;
  msl_state_t next_st;
  msl_evt_if  ev ();

  logic       linked;
  logic       loop_md;
  logic       as_eff;
  logic [1:0] pend_left;
  logic       seek_act;

  // pending-event holder
  msl_event_hold u_hold (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ev      (ev.hold)
  );

  // mode decode; the unused code behaves as default
  assign loop_md = (mode_sel == MSL_MODE_LOOP);
  assign linked  = (mode_sel == MSL_MODE_LINKED) || loop_md;
  assign as_eff  = autosleep_en && linked && !low_noise;

  // detections count only while their detector runs
  assign ev.detect[MSL_CH_ACT]   = act_detect && st.act_run;
  assign ev.detect[MSL_CH_INACT] = inact_detect && st.inact_run;

  // loop clears by itself, otherwise the status read clears
  assign ev.clear = loop_md ? ev.pend : {2{status_read}};

  assign pend_left = ev.pend & ~ev.done;

  // next state of the linker
  always_comb begin
    next_st = st;
    // phase of the alternation
    if (!linked) begin
      next_st.phase = MSL_SEEK_ACT;
    end else if (loop_md && measure_start) begin
      next_st.phase = MSL_SEEK_ACT;
    end else if (ev.done[MSL_CH_ACT]) begin
      next_st.phase = MSL_SEEK_INACT;
    end else if (ev.done[MSL_CH_INACT]) begin
      next_st.phase = MSL_SEEK_ACT;
    end
    // awake flag
    if (loop_md && measure_start) begin
      next_st.awake = 1'h1;
    end else if (ev.done[MSL_CH_ACT]) begin
      next_st.awake = 1'h1;
    end else if (ev.done[MSL_CH_INACT]) begin
      next_st.awake = 1'h0;
    end
    // autosleep between wake-up and measurement
    if (!as_eff) begin
      next_st.wake_mode = 1'h0;
    end else if (ev.done[MSL_CH_ACT]) begin
      next_st.wake_mode = 1'h0;
    end else if (ev.done[MSL_CH_INACT]) begin
      next_st.wake_mode = 1'h1;
    end
    // detector enables; linked waits for service before switching
    seek_act = (next_st.phase == MSL_SEEK_ACT);
    next_st.act_run = act_en &&
      (!linked || (seek_act && pend_left == 2'h0));
    next_st.inact_run = inact_en &&
      (!linked || (!seek_act && pend_left == 2'h0));
    // sample buffer
    next_st.fifo_run = fifo_en && !next_st.wake_mode && !as_eff;
    // reference reload requests
    next_st.act_ref_load = act_ref && act_en &&
      (measure_start || (linked && ev.done[MSL_CH_INACT]));
    next_st.inact_ref_load = inact_ref && inact_en &&
      (measure_start || ev.detect[MSL_CH_INACT]);
    // interrupt pins carry awake level or pending events
    next_st.irq1 = irq1_awake ? next_st.awake : (pend_left != 2'h0);
    next_st.irq2 = irq2_awake ? next_st.awake : (pend_left != 2'h0);
  end

  // state register; activity is sought first and awake is set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st       <= '0;
      st.phase <= MSL_SEEK_ACT;
      st.awake <= MSL_AWAKE_RST;
      st.wake_mode <= MSL_WAKE_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign act_run        = st.act_run;
  assign inact_run      = st.inact_run;
  assign act_ref_load   = st.act_ref_load;
  assign inact_ref_load = st.inact_ref_load;
  assign act_event      = ev.pend[MSL_CH_ACT];
  assign inact_event    = ev.pend[MSL_CH_INACT];
  assign awake          = st.awake;
  assign wake_mode      = st.wake_mode;
  assign fifo_run       = st.fifo_run;
  assign first_irq_pin  = st.irq1;
  assign second_irq_pin = st.irq2;

  // checks
  a_run_needs_en: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !act_en |=> !act_run)
    else $error("activity detector runs while disabled");
  a_link_one_run: assert property (@(posedge sys_clk) disable iff (sys_rst)
    linked && $stable(mode_sel) |=> !(act_run && inact_run))
    else $error("both detectors run in linked mode");
  a_act_stops: assert property (@(posedge sys_clk) disable iff (sys_rst)
    linked && ev.done[MSL_CH_ACT] && !measure_start |=> !act_run)
    else $error("activity still sought after serviced activity");
  a_inact_stops: assert property (@(posedge sys_clk) disable iff (sys_rst)
    linked && ev.done[MSL_CH_INACT] |=> !inact_run)
    else $error("inactivity still sought after serviced inactivity");
  a_awake_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ev.done[MSL_CH_ACT] |=> awake)
    else $error("awake not set after serviced activity");
  a_awake_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ev.done[MSL_CH_INACT] && !ev.done[MSL_CH_ACT]
      && !(loop_md && measure_start) |=> !awake)
    else $error("awake not cleared after serviced inactivity");
  a_loop_autoclr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    loop_md && act_event && !ev.detect[MSL_CH_ACT] |=> !act_event)
    else $error("loop mode did not clear activity event");
  a_loop_awake: assert property (@(posedge sys_clk) disable iff (sys_rst)
    loop_md && measure_start |=> awake ##1 awake)
    else $error("awake not held on entering measurement in loop");
  a_sleep_on_inact: assert property (@(posedge sys_clk) disable iff (sys_rst)
    as_eff && ev.done[MSL_CH_INACT] && !ev.done[MSL_CH_ACT]
      |=> wake_mode)
    else $error("autosleep did not enter wake-up mode");
  a_sleep_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !linked || low_noise |=> !wake_mode)
    else $error("wake-up mode entered while autosleep unusable");
  a_fifo_stopped: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wake_mode |-> !fifo_run)
    else $error("sample buffer runs in wake-up mode");
  a_irq_awake: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq1_awake |=> first_irq_pin == awake)
    else $error("first interrupt pin does not follow awake");
  a_ref_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
    linked && act_ref && act_en && ev.done[MSL_CH_INACT]
      |=> act_ref_load)
    else $error("activity reference not reloaded");
endmodule
`default_nettype wire

/* File: bench/msl_host_model.sv */
// host processor model that services pending motion events
`timescale 1ns/1ps
`default_nettype none
module msl_host_model (
  // clock
  input  wire logic       sys_clk,
  // bench control
  input  wire logic       service_en,
  input  wire logic [1:0] delay,
  // device status
  input  wire logic       act_event,
  input  wire logic       inact_event,
  // host action
  output logic            status_read
);
  // one status read per pending event, after a short random wait;
  // status is looked at 1 ns after the edge, the read driven at 2 ns
  initial begin
    status_read = 1'h0;
    forever begin
      @(posedge sys_clk);
      #1;
      if (service_en && (act_event || inact_event)) begin
        repeat (delay) begin
          @(posedge sys_clk);
          #1;
        end
        #1 status_read = 1'h1;
        @(posedge sys_clk);
        #2 status_read = 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/motion_state_linker_bench.sv */
// self-checking bench for the motion state linker
`timescale 1ns/1ps
`default_nettype none
module motion_state_linker_bench;
  import msl_pkg::*;
  logic       sys_clk = 1'h0, sys_rst = 1'h1;
  logic [1:0] mode_sel = MSL_MODE_RST, delay = 2'h0;
  logic       act_en = 1'h0, inact_en = 1'h0, autosleep_en = 1'h0;
  logic       act_ref = 1'h1, inact_ref = 1'h1, low_noise = 1'h0;
  logic       fifo_en = 1'h0, irq1_awake = 1'h0, irq2_awake = 1'h0;
  logic       measure_start = 1'h0, act_detect = 1'h0;
  logic       inact_detect = 1'h0, service_en = 1'h0;
  logic       status_read, act_run, inact_run, act_ref_load;
  logic       inact_ref_load, act_event, inact_event, awake;
  logic       wake_mode, fifo_run, first_irq_pin, second_irq_pin;
  logic       exp_q[$];
  logic       prev_pend = 1'h0;
  int         fail_count = 0, n_checks = 0, cycles = 0;

  msl_linker uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .mode_sel(mode_sel), .act_en(act_en), .inact_en(inact_en),
    .act_ref(act_ref), .inact_ref(inact_ref),
    .autosleep_en(autosleep_en), .low_noise(low_noise),
    .fifo_en(fifo_en), .irq1_awake(irq1_awake), .irq2_awake(irq2_awake),
    .status_read(status_read), .measure_start(measure_start),
    .act_detect(act_detect), .inact_detect(inact_detect),
    .act_run(act_run), .inact_run(inact_run), .act_ref_load(act_ref_load),
    .inact_ref_load(inact_ref_load), .act_event(act_event),
    .inact_event(inact_event), .awake(awake), .wake_mode(wake_mode),
    .fifo_run(fifo_run), .first_irq_pin(first_irq_pin),
    .second_irq_pin(second_irq_pin));
  msl_host_model host (.sys_clk(sys_clk), .service_en(service_en),
    .delay(delay), .act_event(act_event), .inact_event(inact_event),
    .status_read(status_read));

  // clock
  always #12.5 sys_clk = ~sys_clk;

  task automatic end_sim();
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_bit(input string name, input logic exp,
                           input logic got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  // one detector pulse; note the awake level due when it is cleared
  task automatic detect(input logic inact, input logic exp_awake);
    exp_q.push_back(exp_awake);
    delay = 2'($urandom);
    tick(1);
    {inact_detect, act_detect} = inact ? 2'h2 : 2'h1;
    tick(1);
    {inact_detect, act_detect} = 2'h0;
  endtask

  task automatic wait_clear();
    for (int i = 0; i < 20; i++) begin
      if (!(act_event || inact_event)) break;
      tick(1);
    end
  endtask

  // awake level compared each time a pending event is cleared
  always @(posedge sys_clk) begin
    #1;
    if (prev_pend && !(act_event || inact_event) && exp_q.size() > 0)
      check_bit("awake", exp_q.pop_front(), awake);
    prev_pend = act_event || inact_event;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h0593));
    tick(4);
    sys_rst = 1'h0;
    check_bit("awake", 1'h1, awake);
    check_bit("act_run", 1'h0, act_run);
    check_bit("inact_run", 1'h0, inact_run);
    mode_sel = MSL_MODE_LINKED;
    {act_en, inact_en, autosleep_en, fifo_en, irq1_awake} = 5'h1f;
    irq2_awake = 1'($urandom);
    service_en = 1'h1;
    tick(2);
    check_bit("act_run", 1'h1, act_run);
    check_bit("inact_run", 1'h0, inact_run);
    detect(1'h0, 1'h1);
    wait_clear();
    check_bit("inact_run", 1'h1, inact_run);
    check_bit("act_run", 1'h0, act_run);
    detect(1'h1, 1'h0);
    wait_clear();
    check_bit("act_run", 1'h1, act_run);
    check_bit("act_ref_load", 1'h1, act_ref_load);
    check_bit("wake_mode", 1'h1, wake_mode);
    check_bit("fifo_run", 1'h0, fifo_run);
    detect(1'h0, 1'h1);
    wait_clear();
    tick(1);
    check_bit("first_irq_pin", 1'h1, first_irq_pin);
    check_bit("second_irq_pin", irq2_awake, second_irq_pin);
    check_bit("wake_mode", 1'h0, wake_mode);
    low_noise = 1'h1;
    detect(1'h1, 1'h0);
    wait_clear();
    check_bit("wake_mode", 1'h0, wake_mode);
    // loop mode runs without host service
    mode_sel = MSL_MODE_LOOP;
    service_en = 1'h0;
    low_noise = 1'h0;
    tick(1);
    measure_start = 1'h1;
    tick(1);
    measure_start = 1'h0;
    check_bit("awake", 1'h1, awake);
    detect(1'h0, 1'h1);
    wait_clear();
    check_bit("inact_run", 1'h1, inact_run);
    detect(1'h1, 1'h0);
    wait_clear();
    check_bit("wake_mode", 1'h1, wake_mode);
    detect(1'h0, 1'h1);
    wait_clear();
    // default mode keeps events pending until read
    mode_sel = MSL_MODE_DEFAULT;
    tick(2);
    check_bit("act_run", 1'h1, act_run);
    check_bit("inact_run", 1'h1, inact_run);
    check_bit("fifo_run", 1'h1, fifo_run);
    detect(1'h0, 1'h1);
    tick(3);
    check_bit("act_event", 1'h1, act_event);
    service_en = 1'h1;
    wait_clear();
    detect(1'h1, 1'h0);
    wait_clear();
    check_bit("wake_mode", 1'h0, wake_mode);
    // the spare mode code behaves as default
    mode_sel = 2'h3;
    tick(2);
    check_bit("act_run", 1'h1, act_run);
    check_bit("inact_run", 1'h1, inact_run);
    check_bit("awake_queue", 1'h1, exp_q.size() == 0);
    end_sim();
  end
endmodule
`default_nettype wire
